// ===== rtl/bus_cycle_defs.svh
// constants for the local bus cycle control
// Summary of operation
// - every bus cycle spans T1 T2 T3 T4
// - processor drives address T1, data T2 to T4
// - wait states between T3 and T4, one clock
// - idle clocks between cycles issue no command
// - status lines valid during T1 each cycle
// - status code decodes to eight cycle types
// - address latch strobe in T1, leading edge latches
// - upper byte enable and bit zero select bytes
// - read: direction to receive at end of T1
// - read command held from T2 to T4
// - read: buffer enable asserted at start of T3
// - ready sampled late T3 and each wait
// - read T4 ends command, buffer disabled in the same clock
// - write: direction stays high entire cycle
// - write: early strobe T2, normal strobe T3
// - write T4 drops strobe, buffer disabled in the same clock
// - two acknowledge cycles, timed like reads
// - second acknowledge returns source byte low lines
// - processor outputs 20-bit address in T1
// - latched bits feed io and ram decode
// - from T2 the lines carry data
// - time-out restarts on latch strobe, about 10 ms
// - fitted link forces ready, time-out interrupt
`ifndef BUS_CYCLE_DEFS_SVH
`define BUS_CYCLE_DEFS_SVH
// ------------------------------------------------
// status codes (s2 s1 s0)
// ------------------------------------------------
`define CS_IRQ_ACK_N 3'h0
`define CS_IORD 3'h1
`define CS_IOWR 3'h2
`define CS_HALT 3'h3
`define CS_CODE 3'h4
`define CS_MRD 3'h5
`define CS_MWR 3'h6
`define CS_PASSIVE 3'h7
// ------------------------------------------------
// timing
// ------------------------------------------------
`define CLK_PERIOD_NS 25
`define TIMEOUT_MS 10
`define TIMEOUT_CYCLES ((`TIMEOUT_MS * 1000000) / `CLK_PERIOD_NS)
`define TIMEOUT_W 19
`define ADDR_W 20
`define DATA_W 16
`endif

// ===== rtl/bus_cycle_pkg.sv
// types shared by both ends of the local bus
package bus_cycle_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_T1 = 3'h1,
        ST_T2 = 3'h3,
        ST_T3 = 3'h2,
        ST_TW = 3'h6,
        ST_T4 = 3'h4
    } bus_state_t;
    typedef logic [2:0] cycle_status_t;
endpackage

// ===== rtl/local_bus_if.sv
// interface joining the processor end and the cycle controller
`timescale 1ns/1ps
interface local_bus_if;
    logic [2:0] cycle_status;
    logic [19:0] ad_out;
    logic ad_oe_n;
    logic [15:0] ad_in;
    logic upper_byte_enable_n;
    logic ready;
    modport cpu
    (
        output cycle_status,
        output ad_out,
        output ad_oe_n,
        output upper_byte_enable_n,
        input ad_in,
        input ready
    );
    modport ctl
    (
        input cycle_status,
        input ad_out,
        input ad_oe_n,
        input upper_byte_enable_n,
        output ad_in,
        output ready
    );
endinterface

// ===== rtl/cpu_bus_end.sv
// processor end: runs T1..T4 cycles with wait states on the local bus
`timescale 1ns/1ps
`include "bus_cycle_defs.svh"
module cpu_bus_end
(
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    input wire logic i_req,
    input wire bus_cycle_pkg::cycle_status_t i_status,
    input wire logic [19:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic i_upper_byte_enable_n,
    output logic o_busy,
    output logic o_done,
    output logic [15:0] o_rdata,
    output logic [9:0] o_vector_addr,
    local_bus_if.cpu bus
);
    import bus_cycle_pkg::*;
    // ------------------------------------------------
    // cycle sequencer
    // ------------------------------------------------
    bus_state_t st_r, st_nxt;
    cycle_status_t stat_r, stat_nxt;
    logic [15:0] wdata_r, wdata_nxt, rdata_r, rdata_nxt;
    logic ube_r, ube_nxt, done_r, done_nxt, inta2_r, inta2_nxt, busy_r, busy_nxt;
    logic [9:0] vec_r, vec_nxt;
    logic [19:0] ad_r, ad_nxt;
    logic oe_n_r, oe_n_nxt;
    cycle_status_t cs_r, cs_nxt;

    function automatic logic is_read(input cycle_status_t s);
        is_read = (s == `CS_IORD) || (s == `CS_CODE) || (s == `CS_MRD) || (s == `CS_IRQ_ACK_N);
    endfunction

    always_comb
    begin
        st_nxt = st_r;
        stat_nxt = stat_r;
        wdata_nxt = wdata_r;
        rdata_nxt = rdata_r;
        ube_nxt = ube_r;
        done_nxt = 1'b0;
        inta2_nxt = inta2_r;
        vec_nxt = vec_r;
        ad_nxt = ad_r;
        oe_n_nxt = 1'b1;
        cs_nxt = `CS_PASSIVE;
        case (st_r)
            ST_IDLE:
            begin
                if (i_req && i_status != `CS_PASSIVE && i_status != `CS_HALT)
                begin
                    st_nxt = ST_T1;
                    stat_nxt = i_status;
                    wdata_nxt = i_wdata;
                    ube_nxt = i_upper_byte_enable_n;
                    cs_nxt = i_status;
                    ad_nxt = (i_status == `CS_IRQ_ACK_N) ? 20'h00000 : i_addr;
                    oe_n_nxt = (i_status == `CS_IRQ_ACK_N);
                end
            end
            ST_T1:
            begin
                st_nxt = ST_T2;
                oe_n_nxt = is_read(stat_r);
                ad_nxt = {4'h0, wdata_r};
            end
            ST_T2:
            begin
                st_nxt = ST_T3;
                oe_n_nxt = is_read(stat_r);
            end
            ST_T3, ST_TW:
            begin
                oe_n_nxt = is_read(stat_r);
                st_nxt = bus.ready ? ST_T4 : ST_TW;
            end
            ST_T4:
            begin
                st_nxt = ST_IDLE;
                done_nxt = 1'b1;
                rdata_nxt = bus.ad_in;
                if (stat_r == `CS_IRQ_ACK_N)
                begin
                    inta2_nxt = ~inta2_r;
                    if (inta2_r)
                        vec_nxt = {bus.ad_in[7:0], 2'b00};
                end
            end
            default:
                st_nxt = ST_IDLE;
        endcase
        busy_nxt = (st_nxt != ST_IDLE);
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            st_r <= ST_IDLE;
            stat_r <= `CS_PASSIVE;
            wdata_r <= 16'h0000;
            rdata_r <= 16'h0000;
            ube_r <= 1'b1;
            done_r <= 1'b0;
            busy_r <= 1'b0;
            inta2_r <= 1'b0;
            vec_r <= 10'h000;
            ad_r <= 20'h00000;
            oe_n_r <= 1'b1;
            cs_r <= `CS_PASSIVE;
        end
        else
        begin
            st_r <= st_nxt;
            stat_r <= stat_nxt;
            wdata_r <= wdata_nxt;
            rdata_r <= rdata_nxt;
            ube_r <= ube_nxt;
            done_r <= done_nxt;
            busy_r <= busy_nxt;
            inta2_r <= inta2_nxt;
            vec_r <= vec_nxt;
            ad_r <= ad_nxt;
            oe_n_r <= oe_n_nxt;
            cs_r <= cs_nxt;
        end
    end

    assign bus.cycle_status = cs_r;
    assign bus.ad_out = ad_r;
    assign bus.ad_oe_n = oe_n_r;
    assign bus.upper_byte_enable_n = ube_r;
    assign o_busy = busy_r;
    assign o_done = done_r;
    assign o_rdata = rdata_r;
    assign o_vector_addr = vec_r;
endmodule

// ===== rtl/bus_cycle_ctrl.sv
// controller end: status decode, latch, command strobes and bus time-out
`timescale 1ns/1ps
`include "bus_cycle_defs.svh"
module bus_cycle_ctrl
(
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    input wire logic i_dev_ready,
    input wire logic i_timeout_link,
    input wire logic [15:0] i_dev_rdata,
    output logic o_addr_latch_strobe,
    output logic [19:0] o_latched_addr,
    output logic o_low_byte_sel,
    output logic o_high_byte_sel,
    output logic [12:0] o_io_decode_addr,
    output logic o_ram_select,
    output logic o_transfer_direction,
    output logic o_data_buffer_enable,
    output logic o_mem_read_cmd_n,
    output logic o_io_read_cmd_n,
    output logic o_mem_write_cmd_n,
    output logic o_io_write_cmd_n,
    output logic o_early_mem_write_n,
    output logic o_early_io_write_n,
    output logic o_irq_ack_n,
    output logic o_bus_expired_irq_n,
    output logic [15:0] o_wdata,
    output bus_cycle_pkg::bus_state_t o_state,
    local_bus_if.ctl bus
);
    import bus_cycle_pkg::*;
    // ------------------------------------------------
    // state tracking mirrors the processor's T states
    // ------------------------------------------------
    bus_state_t st_r, st_nxt;
    cycle_status_t stat_r, stat_nxt;
    logic ale_r, ale_nxt;
    logic [19:0] lat_r, lat_nxt;
    logic lo_r, lo_nxt, hi_r, hi_nxt;
    logic dtr_r, dtr_nxt, den_r, den_nxt;
    logic mrd_r, mrd_nxt, iord_r, iord_nxt, mwr_r, mwr_nxt, iowr_r, iowr_nxt;
    logic amw_r, amw_nxt, aiow_r, aiow_nxt, ack_r, ack_nxt;
    logic [15:0] wd_r, wd_nxt;
    logic [`TIMEOUT_W-1:0] to_cnt_r, to_cnt_nxt;
    logic expired_r, expired_nxt;
    logic rdy_r, rdy_nxt;
    logic ready_eff;
    logic rd_cyc, wr_cyc;

    function automatic logic is_read(input cycle_status_t s);
        is_read = (s == `CS_IORD) || (s == `CS_CODE) || (s == `CS_MRD) || (s == `CS_IRQ_ACK_N);
    endfunction

    function automatic logic is_write(input cycle_status_t s);
        is_write = (s == `CS_IOWR) || (s == `CS_MWR);
    endfunction

    // time-out via link forces ready so a hung wait ends
    assign ready_eff = i_dev_ready | (i_timeout_link & expired_r);
    assign rd_cyc = is_read(stat_r);
    assign wr_cyc = is_write(stat_r);

    always_comb
    begin
        st_nxt = st_r;
        stat_nxt = stat_r;
        ale_nxt = 1'b0;
        lat_nxt = lat_r;
        lo_nxt = lo_r;
        hi_nxt = hi_r;
        dtr_nxt = 1'b1;
        den_nxt = 1'b0;
        mrd_nxt = 1'b1;
        iord_nxt = 1'b1;
        mwr_nxt = 1'b1;
        iowr_nxt = 1'b1;
        amw_nxt = 1'b1;
        aiow_nxt = 1'b1;
        ack_nxt = 1'b1;
        wd_nxt = wd_r;
        rdy_nxt = 1'b0;
        case (st_r)
            ST_IDLE:
            begin
                // no command in idle clocks
                if (bus.cycle_status != `CS_PASSIVE && bus.cycle_status != `CS_HALT)
                begin
                    st_nxt = ST_T1;
                    stat_nxt = bus.cycle_status;
                    ale_nxt = 1'b1;
                    // address stands only in the processor's T1, one clock ahead of ours
                    if (!bus.ad_oe_n)
                    begin
                        lat_nxt = bus.ad_out;
                        lo_nxt = ~bus.ad_out[0];
                        hi_nxt = ~bus.upper_byte_enable_n;
                    end
                end
            end
            ST_T1:
            begin
                st_nxt = ST_T2;
                dtr_nxt = ~rd_cyc;
                mrd_nxt = ~(stat_r == `CS_MRD || stat_r == `CS_CODE);
                iord_nxt = ~(stat_r == `CS_IORD);
                ack_nxt = ~(stat_r == `CS_IRQ_ACK_N);
                amw_nxt = ~(stat_r == `CS_MWR);
                aiow_nxt = ~(stat_r == `CS_IOWR);
                den_nxt = wr_cyc;
            end
            ST_T2, ST_T3, ST_TW:
            begin
                if (st_r == ST_T2)
                    st_nxt = ST_T3;
                else
                    st_nxt = ready_eff ? ST_T4 : ST_TW;
                // commands hold until T4 entry
                dtr_nxt = ~rd_cyc;
                mrd_nxt = ~(stat_r == `CS_MRD || stat_r == `CS_CODE);
                iord_nxt = ~(stat_r == `CS_IORD);
                ack_nxt = ~(stat_r == `CS_IRQ_ACK_N);
                amw_nxt = ~(stat_r == `CS_MWR);
                aiow_nxt = ~(stat_r == `CS_IOWR);
                mwr_nxt = ~(stat_r == `CS_MWR);
                iowr_nxt = ~(stat_r == `CS_IOWR);
                den_nxt = 1'b1;
                wd_nxt = bus.ad_out[15:0];
                if (st_r != ST_T2 && ready_eff)
                begin
                    // entering T4: strobes drop, buffers float
                    mrd_nxt = 1'b1;
                    iord_nxt = 1'b1;
                    ack_nxt = 1'b1;
                    mwr_nxt = 1'b1;
                    iowr_nxt = 1'b1;
                    amw_nxt = 1'b1;
                    aiow_nxt = 1'b1;
                    den_nxt = 1'b0;
                    rdy_nxt = 1'b1;
                end
            end
            ST_T4:
                st_nxt = ST_IDLE;
            default:
                st_nxt = ST_IDLE;
        endcase
    end

    // ------------------------------------------------
    // bus time-out: restarts on each latch strobe leading edge
    // ------------------------------------------------
    always_comb
    begin
        to_cnt_nxt = to_cnt_r;
        expired_nxt = expired_r;
        if (ale_nxt)
        begin
            to_cnt_nxt = '0;
            expired_nxt = 1'b0;
        end
        else if (to_cnt_r == `TIMEOUT_W'(`TIMEOUT_CYCLES - 1))
            expired_nxt = 1'b1;
        else
            to_cnt_nxt = to_cnt_r + `TIMEOUT_W'(1);
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            st_r <= ST_IDLE;
            stat_r <= `CS_PASSIVE;
            ale_r <= 1'b0;
            lat_r <= 20'h00000;
            lo_r <= 1'b0;
            hi_r <= 1'b0;
            dtr_r <= 1'b1;
            den_r <= 1'b0;
            mrd_r <= 1'b1;
            iord_r <= 1'b1;
            mwr_r <= 1'b1;
            iowr_r <= 1'b1;
            amw_r <= 1'b1;
            aiow_r <= 1'b1;
            ack_r <= 1'b1;
            wd_r <= 16'h0000;
            to_cnt_r <= '0;
            expired_r <= 1'b0;
            rdy_r <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
            stat_r <= stat_nxt;
            ale_r <= ale_nxt;
            lat_r <= lat_nxt;
            lo_r <= lo_nxt;
            hi_r <= hi_nxt;
            dtr_r <= dtr_nxt;
            den_r <= den_nxt;
            mrd_r <= mrd_nxt;
            iord_r <= iord_nxt;
            mwr_r <= mwr_nxt;
            iowr_r <= iowr_nxt;
            amw_r <= amw_nxt;
            aiow_r <= aiow_nxt;
            ack_r <= ack_nxt;
            wd_r <= wd_nxt;
            to_cnt_r <= to_cnt_nxt;
            expired_r <= expired_nxt;
            rdy_r <= rdy_nxt;
        end
    end

    // ------------------------------------------------
    // outputs
    // ------------------------------------------------
    assign bus.ready = rdy_r | ready_eff;
    assign bus.ad_in = i_dev_rdata;
    assign o_addr_latch_strobe = ale_r;
    assign o_latched_addr = lat_r;
    assign o_low_byte_sel = lo_r;
    assign o_high_byte_sel = hi_r;
    assign o_io_decode_addr = lat_r[15:3];
    assign o_ram_select = lat_r[19];
    assign o_transfer_direction = dtr_r;
    assign o_data_buffer_enable = den_r;
    assign o_mem_read_cmd_n = mrd_r;
    assign o_io_read_cmd_n = iord_r;
    assign o_mem_write_cmd_n = mwr_r;
    assign o_io_write_cmd_n = iowr_r;
    assign o_early_mem_write_n = amw_r;
    assign o_early_io_write_n = aiow_r;
    assign o_irq_ack_n = ack_r;
    assign o_bus_expired_irq_n = ~expired_r;
    assign o_wdata = wd_r;
    assign o_state = st_r;
endmodule

// ===== sim/bus_cycle_assertions.sv
// concurrent checks of the cycle controller beside the local bus
`timescale 1ns/1ps
module bus_cycle_assertions
(
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    input wire logic [2:0] cycle_status,
    input wire logic ready,
    input wire logic [19:0] ad_out,
    input wire logic ad_oe_n,
    input wire logic upper_byte_enable_n,
    input wire logic o_high_byte_sel,
    input wire logic o_addr_latch_strobe,
    input wire logic [19:0] o_latched_addr,
    input wire logic o_low_byte_sel,
    input wire logic [12:0] o_io_decode_addr,
    input wire logic o_ram_select,
    input wire logic o_transfer_direction,
    input wire logic o_data_buffer_enable,
    input wire logic o_mem_read_cmd_n,
    input wire logic o_io_read_cmd_n,
    input wire logic o_mem_write_cmd_n,
    input wire logic o_io_write_cmd_n,
    input wire logic o_early_mem_write_n,
    input wire logic o_irq_ack_n,
    input wire bus_cycle_pkg::bus_state_t o_state
);
    import bus_cycle_pkg::*;
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_resetn);
    // ------------------------------------------------
    // assertions
    // ------------------------------------------------
    // status is only valid in the clock before the strobe, hence $past
    a_ale_one_clock: assert property ($rose(o_addr_latch_strobe) |=> !o_addr_latch_strobe)
        else $error("latch strobe longer than one clock");
    a_mem_read_decode: assert property ($rose(o_addr_latch_strobe) &&
        $past(cycle_status) inside {3'h4, 3'h5} |=> !o_mem_read_cmd_n && o_io_read_cmd_n)
        else $error("memory read not decoded");
    a_io_read_decode: assert property ($rose(o_addr_latch_strobe) &&
        $past(cycle_status) == 3'h1 |=> !o_io_read_cmd_n && o_mem_read_cmd_n)
        else $error("io read not decoded");
    a_ack_no_read: assert property ($rose(o_addr_latch_strobe) &&
        $past(cycle_status) == 3'h0 |=> !o_irq_ack_n && o_mem_read_cmd_n && o_io_read_cmd_n)
        else $error("acknowledge not decoded");
    a_read_den_late: assert property ($fell(o_mem_read_cmd_n) |->
        !o_data_buffer_enable ##1 o_data_buffer_enable)
        else $error("read buffer enable not one clock after command");
    a_write_strobe_order: assert property ($fell(o_early_mem_write_n) |->
        o_data_buffer_enable && o_mem_write_cmd_n ##1 !o_mem_write_cmd_n)
        else $error("write strobes out of order");
    a_write_dir_high: assert property (!o_early_mem_write_n || !o_mem_write_cmd_n |->
        o_transfer_direction)
        else $error("direction low during write");
    a_read_dir_low: assert property (!o_mem_read_cmd_n || !o_io_read_cmd_n ||
        !o_irq_ack_n |-> !o_transfer_direction)
        else $error("direction high during read");
    a_wait_holds_cmd: assert property (!o_mem_read_cmd_n && !ready && !$past(ready) |=>
        !o_mem_read_cmd_n)
        else $error("command dropped while not ready");
    a_cmd_release: assert property (!o_mem_read_cmd_n && ready |-> ##[1:2] o_mem_read_cmd_n)
        else $error("command not released after ready");
    a_latch_fields: assert property ($fell(o_addr_latch_strobe) |=>
        o_low_byte_sel == !o_latched_addr[0] && o_io_decode_addr == o_latched_addr[15:3]
        && o_ram_select == o_latched_addr[19])
        else $error("latched address fields inconsistent");
    a_latch_capture: assert property ($rose(o_addr_latch_strobe) && !$past(ad_oe_n) |->
        o_latched_addr == $past(ad_out) && o_high_byte_sel == !$past(upper_byte_enable_n))
        else $error("address not latched from the bus");
    a_idle_quiet: assert property (o_state == ST_IDLE && $past(o_state) == ST_IDLE |->
        &{o_mem_read_cmd_n, o_io_read_cmd_n, o_mem_write_cmd_n, o_io_write_cmd_n,
        o_early_mem_write_n, o_irq_ack_n} && !o_data_buffer_enable)
        else $error("command issued while idle");
    c_read_wait: cover property ($fell(o_mem_read_cmd_n) ##2 !ready);
    c_write: cover property ($fell(o_mem_write_cmd_n));
    c_ack: cover property ($fell(o_irq_ack_n));
endmodule

// ===== sim/cpu_local_bus_cycle_control_test.sv
// self-checking bench: processor end and controller joined by the local bus
`timescale 1ns/1ps
module cpu_local_bus_cycle_control_test;
    import bus_cycle_pkg::*;
    logic i_ref_clk = 1'b0;
    logic i_resetn = 1'b0;
    logic i_req = 1'b0;
    cycle_status_t i_status = 3'h7;
    logic [19:0] i_addr = 20'h0;
    logic [15:0] i_wdata = 16'h0;
    logic i_upper_byte_enable_n = 1'b1;
    logic i_dev_ready = 1'b0;
    logic [15:0] i_dev_rdata = 16'h0;
    logic i_timeout_link = 1'b0;
    logic expired_n;
    logic busy, done, ale, lo_sel, hi_sel, ram_sel, dir, data_buffer_enable, mrd_n, iord_n;
    logic mwr_n, iowr_n, emw_n, eiow_n, ack_n;
    logic [15:0] rdata, wdata_seen;
    logic [9:0] vec;
    logic [19:0] lat;
    logic [12:0] iodec;
    bus_state_t state;
    int errors = 0;
    int n_tests = 0;
    int cnt [0:8];
    string nm [0:8] = '{"ale", "mrd", "iord", "mwr", "iowr", "emw", "eiow", "ack", "dirlow"};
    always #12.5 i_ref_clk = ~i_ref_clk;
    local_bus_if local_bus_if_i();
    cpu_bus_end cpu_bus_end_i(.i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_req(i_req),
        .i_status(i_status), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_upper_byte_enable_n(i_upper_byte_enable_n), .o_busy(busy), .o_done(done),
        .o_rdata(rdata), .o_vector_addr(vec), .bus(local_bus_if_i.cpu));
    // a 10 ms expiry is far beyond the run, so the fitted link must never force ready here
    bus_cycle_ctrl bus_cycle_ctrl_i(.i_ref_clk(i_ref_clk), .i_resetn(i_resetn),
        .i_dev_ready(i_dev_ready), .i_timeout_link(i_timeout_link), .i_dev_rdata(i_dev_rdata),
        .o_addr_latch_strobe(ale), .o_latched_addr(lat), .o_low_byte_sel(lo_sel),
        .o_high_byte_sel(hi_sel), .o_io_decode_addr(iodec), .o_ram_select(ram_sel),
        .o_transfer_direction(dir), .o_data_buffer_enable(data_buffer_enable), .o_mem_read_cmd_n(mrd_n),
        .o_io_read_cmd_n(iord_n), .o_mem_write_cmd_n(mwr_n), .o_io_write_cmd_n(iowr_n),
        .o_early_mem_write_n(emw_n), .o_early_io_write_n(eiow_n), .o_irq_ack_n(ack_n),
        .o_bus_expired_irq_n(expired_n), .o_wdata(wdata_seen), .o_state(state),
        .bus(local_bus_if_i.ctl));
    bus_cycle_assertions bus_cycle_assertions_i(.i_ref_clk(i_ref_clk), .i_resetn(i_resetn),
        .cycle_status(local_bus_if_i.cycle_status), .ready(local_bus_if_i.ready),
        .ad_out(local_bus_if_i.ad_out), .ad_oe_n(local_bus_if_i.ad_oe_n),
        .upper_byte_enable_n(local_bus_if_i.upper_byte_enable_n), .o_high_byte_sel(hi_sel),
        .o_addr_latch_strobe(ale), .o_latched_addr(lat), .o_low_byte_sel(lo_sel),
        .o_io_decode_addr(iodec), .o_ram_select(ram_sel), .o_transfer_direction(dir),
        .o_data_buffer_enable(data_buffer_enable), .o_mem_read_cmd_n(mrd_n), .o_io_read_cmd_n(iord_n),
        .o_mem_write_cmd_n(mwr_n), .o_io_write_cmd_n(iowr_n), .o_early_mem_write_n(emw_n),
        .o_irq_ack_n(ack_n), .o_state(state));
    // ------------------------------------------------
    // shared tasks
    // ------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] expv);
        n_tests++;
        if (seen !== expv)
        begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, expv, seen);
        end
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // one whole cycle; ready is raised late in the clock whose end should leave T3/wait
    task automatic run_cycle(input cycle_status_t st, input logic [19:0] a, input logic [15:0] d,
        input logic ube, input int w);
        int k;
        int c;
        int rd;
        int e [0:8];
        logic [8:0] v;
        cnt = '{default: 0};
        rd = (st == 3'h4 || st == 3'h5);
        e = '{1, rd ? 2 + w : 0, st == 3'h1 ? 2 + w : 0, st == 3'h6 ? 1 + w : 0,
            st == 3'h2 ? 1 + w : 0, st == 3'h6 ? 2 + w : 0, st == 3'h2 ? 2 + w : 0,
            st == 3'h0 ? 2 + w : 0, (rd || st < 3'h2) ? 3 + w : 0};
        i_dev_ready = 1'b0;
        i_req = 1'b1;
        i_status = st;
        i_addr = a;
        i_wdata = d;
        i_upper_byte_enable_n = ube;
        i_dev_rdata = d ^ 16'h5a5a;
        @(negedge i_ref_clk);
        i_req = 1'b0;
        for (k = 0; k < 40 && done !== 1'b1; k++)
        begin
            v = {ale, !mrd_n, !iord_n, !mwr_n, !iowr_n, !emw_n, !eiow_n, !ack_n, !dir};
            for (int j = 0; j < 9; j++)
                cnt[j] += int'(v[8 - j]);
            c = cnt[1] + cnt[2] + cnt[5] + cnt[6] + cnt[7];
            if (c == 2 + w)
                i_dev_ready = 1'b1;
            @(negedge i_ref_clk);
        end
        check("done", done, 1'b1);
        for (int j = 0; j < 9; j++)
            check(nm[j], cnt[j], e[j]);
        if (rd || st == 3'h1)
            check("read data", rdata, d ^ 16'h5a5a);
        if (st == 3'h2 || st == 3'h6)
            check("write data", wdata_seen, d);
        if (st != 3'h0)
        begin
            check("latched", lat, a);
            check("low sel", lo_sel, !a[0]);
            check("high sel", hi_sel, !ube);
            check("io decode", iodec, a[15:3]);
            check("ram sel", ram_sel, a[19]);
        end
    endtask
    // ------------------------------------------------
    // scenarios
    // ------------------------------------------------
    task automatic t_codes;
        cycle_status_t cs [0:4] = '{3'h1, 3'h2, 3'h4, 3'h5, 3'h6};
        for (int i = 0; i < 5; i++)
            run_cycle(cs[i], 20'h8a5b3 + 20'(i * 12609), 16'hc3a5 ^ 16'(i), i[0], 0);
    endtask
    task automatic t_waits;
        i_timeout_link = 1'b1;
        run_cycle(3'h5, 20'h0fff7, 16'h0f1e, 1'b0, 3);
        run_cycle(3'h6, 20'h7fffe, 16'hbeef, 1'b1, 2);
        run_cycle(3'h1, 20'hffff8, 16'h2d3c, 1'b0, 1);
        run_cycle(3'h2, 20'h00009, 16'h8001, 1'b1, 4);
        check("expired", expired_n, 1'b1);
        i_timeout_link = 1'b0;
    endtask
    task automatic t_ack;
        run_cycle(3'h0, 20'h0, 16'h1111, 1'b1, 0);
        run_cycle(3'h0, 20'h0, 16'h00a7, 1'b1, 1);
        check("vector", vec, {i_dev_rdata[7:0], 2'b00});
    endtask
    // halt and passive must start nothing
    task automatic t_refused;
        int seen;
        cycle_status_t cs [0:1] = '{3'h3, 3'h7};
        for (int i = 0; i < 2; i++)
        begin
            seen = 0;
            i_req = 1'b1;
            i_status = cs[i];
            for (int k = 0; k < 8; k++)
            begin
                @(negedge i_ref_clk);
                i_req = 1'b0;
                seen += int'(ale === 1'b1 || busy === 1'b1);
            end
            check("refused", seen, 0);
        end
    endtask
    initial
    begin
        repeat (10) @(negedge i_ref_clk);
        i_resetn = 1'b1;
        @(negedge i_ref_clk);
        t_codes();
        t_waits();
        t_ack();
        t_refused();
        close_out();
    end
    // whole run needs well under 400 clocks
    initial
    begin
        #(25 * 3000);
        errors++;
        close_out();
    end
endmodule
